// File: logic/lockline_pkg.sv
/*
 * Shared constants and types of the lock-line atomic update unit: command
 * encodings, the command and status carriers, the controller states and the
 * values that registers take after reset.
 * Assumes one core clock and a synchronous active-low reset in every user.
 */
// Summary of operation
// - Four lock-line commands; three run at once and carry no tag.
// - Immediate commands ignore queued sync, ordering and barrier commands.
// - Taking any lock-line command still needs a free queue slot.
// - Queued unconditional put waits until its tag group has drained.
// - Write-through or cache-inhibited targets are refused and raise class 1 interrupt.
// - With coherence set, a foreign store to the granule kills the reservation.
// - Get-and-reserve copies one line to local store and sets a reservation.
// - Commands from the proxy queue are refused.
// - Immediate command during another immediate halts the queue and interrupts the host.
// - Any conditional put clears the reservation, covering context switch cleanup.
// - Get-and-reserve outside the held granule drops it with a lost event.
// - A context switch drops the reservation with a lost event.
// - The lost event is only a hint that granule data may have changed.
// - Conditional put stores only while a matching reservation is held.
// - Conditional put takes one whole line from local store.
// - A status read with nothing to report waits until an immediate command completes.
// - Reservation granule size must equal the host processor granule size.
// - Both unconditional puts store one cacheable line.
// - Unconditional puts store whether or not a reservation is held.
package lockline_pkg;

    // Address and tag widths of the command channel.
    localparam int EA_W = 64;
    localparam int LS_AW = 18;
    localparam int TAG_W = 5;
    localparam int NUM_TAGS = 32;

    // The four lock-line commands.
    typedef enum logic [1:0] {
        OP_GET_RESERVE = 2'h0,
        OP_PUT_COND = 2'h1,
        OP_PUT_UNCOND = 2'h2,
        OP_PUT_QUEUED = 2'h3
    } op_t;

    // One command as the core presents it.
    typedef struct packed {
        op_t op;
        logic [TAG_W-1:0] tag;
        logic [LS_AW-1:0] ls_off;
        logic [EA_W-1:0] ea;
        logic wt;
        logic ci;
        logic coh;
        logic proxy;
    } cmd_t;

    // Atomic status word; one bit per kind of immediate-command completion.
    typedef struct packed {
        logic get_done;
        logic put_uncond_done;
        logic put_cond_ok;
        logic put_cond_fail;
    } stat_t;

    // Controller states, one-hot.
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_MS_RD = 6'h02,
        S_LS_WR = 6'h04,
        S_LS_RD = 6'h08,
        S_MS_WR = 6'h10,
        S_DONE = 6'h20
    } state_t;

    // Values after reset.
    localparam stat_t STAT_RESET = 4'h0;
    localparam state_t STATE_RESET = S_IDLE;
    localparam op_t OP_RESET = OP_GET_RESERVE;

endpackage : lockline_pkg

// File: logic/line_buffer.sv
/*
 * Small line buffer holding one cache line as a number of beats, with a
 * registered read port.
 * Assumes the caller presents the read address one cycle before it uses data.
 */
`timescale 1ns/10ps
module line_buffer #(
    parameter int WIDTH = 128,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem_r [DEPTH];

    if (DEPTH > (2 ** AW) || DEPTH < 2) begin : g_bad_depth
        $error("line_buffer depth does not fit its address width");
    end

    // Stores one beat when wr_en is set and reads one beat every cycle.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem_r[rd_addr];
        end
    end

endmodule : line_buffer

// File: logic/lockline_unit.sv
/*
 * Lock-line atomic update unit: takes get-and-reserve, conditional put,
 * unconditional put and queued unconditional put, moves one line between
 * local store and main storage, keeps one reservation and reports status.
 * Assumes all inputs come from logic on CORE_CLK; memory ports hold a request
 * until a one-cycle acknowledge, with read data valid in the acknowledge cycle.
 */
`timescale 1ns/10ps
module lockline_unit
    import lockline_pkg::*;
#(
    parameter int LINE_LG2 = 7,
    parameter int BEAT_BYTES = 16,
    parameter int GRANULE_LG2 = 7,
    parameter int HOST_GRANULE_LG2 = 7
) (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic CMD_VALID,
    input wire cmd_t CMD,
    input wire logic QSLOT_FREE,
    output logic CMD_ACK,
    output logic CMD_REJECT,
    input wire logic [NUM_TAGS-1:0] TAG_IDLE,
    output logic QPUT_DONE,
    output logic [TAG_W-1:0] QPUT_DONE_TAG,
    input wire logic STAT_RD,
    output logic STAT_VALID,
    output stat_t STAT_DATA,
    output logic LS_REQ,
    output logic LS_WE,
    output logic [LS_AW-1:0] LS_ADDR,
    output logic [8*BEAT_BYTES-1:0] LS_WDATA,
    input wire logic [8*BEAT_BYTES-1:0] LS_RDATA,
    input wire logic LS_ACK,
    output logic MS_REQ,
    output logic MS_WE,
    output logic [EA_W-1:0] MS_ADDR,
    output logic [8*BEAT_BYTES-1:0] MS_WDATA,
    input wire logic [8*BEAT_BYTES-1:0] MS_RDATA,
    input wire logic MS_ACK,
    input wire logic SNOOP_VALID,
    input wire logic [EA_W-1:0] SNOOP_EA,
    input wire logic CTX_SWITCH,
    output logic RES_LOST_EVT,
    output logic RES_HELD,
    output logic QUEUE_HALT,
    output logic HOST_INT,
    output logic CLASS1_INT
);

    localparam int BEAT_W = 8 * BEAT_BYTES;
    localparam int BYTE_LG2 = $clog2(BEAT_BYTES);
    localparam int BEATS = (2 ** LINE_LG2) / BEAT_BYTES;
    localparam int BEAT_LG2 = $clog2(BEATS);
    localparam logic [BEAT_LG2-1:0] LAST_BEAT = BEAT_LG2'(BEATS - 1);

    // Refuse geometries the beat counter and granule compare cannot serve.
    if (GRANULE_LG2 != HOST_GRANULE_LG2) begin : g_bad_granule
        $error("reservation granule must match the host processor granule");
    end
    if (BEATS < 2 || (2 ** BYTE_LG2) != BEAT_BYTES || GRANULE_LG2 < LINE_LG2 || LINE_LG2 >= LS_AW) begin : g_bad_geom
        $error("unsupported line, beat or granule size");
    end

    // True when two addresses fall in the same reservation granule.
    function automatic logic same_granule(input logic [EA_W-1:0] a, input logic [EA_W-1:0] b);
        same_granule = (a >> GRANULE_LG2) == (b >> GRANULE_LG2);
    endfunction : same_granule

    ////////////////////////////////////////////////////////////////////////////
    // State.
    state_t state_r, state_nxt;
    op_t op_r;
    logic [LS_AW-1:0] ls_off_r;
    logic [EA_W-1:0] ea_r;
    logic coh_r;
    logic [TAG_W-1:0] tag_r;
    logic [BEAT_LG2-1:0] beat_r, beat_nxt;
    logic ms_req_r, ls_req_r, ms_we_r, ls_we_r;
    logic [EA_W-1:0] ms_addr_r;
    logic [LS_AW-1:0] ls_addr_r;
    logic imm_busy_r, halt_r, host_int_r, class1_r;
    logic cmd_ack_r, cmd_rej_r;
    logic qp_valid_r;
    cmd_t qp_r;
    logic qdone_r;
    logic [TAG_W-1:0] qdone_tag_r;
    stat_t stat_r, stat_data_r;
    logic stat_pend_r, stat_valid_r;
    logic res_valid_r, res_coh_r, res_lost_r;
    logic [EA_W-1:0] res_ea_r;
    logic [BEAT_W-1:0] buf_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Command intake decode.
    logic is_imm, cmd_new, attr_bad, rej_proxy, rej_attr, rej_overlap, cmd_ok;
    logic take_imm, take_q, launch_q;
    assign is_imm = CMD.op != OP_PUT_QUEUED;
    assign cmd_new = CMD_VALID && !cmd_ack_r && !cmd_rej_r && !halt_r;
    assign attr_bad = CMD.wt || CMD.ci;
    assign rej_proxy = cmd_new && CMD.proxy;
    assign rej_attr = cmd_new && !CMD.proxy && attr_bad;
    assign rej_overlap = cmd_new && !CMD.proxy && !attr_bad && is_imm && imm_busy_r;
    assign cmd_ok = cmd_new && !CMD.proxy && !attr_bad && !(is_imm && imm_busy_r) && QSLOT_FREE;
    // Immediate commands start as soon as the engine is free, whatever waits in the queue.
    assign take_imm = cmd_ok && is_imm && state_r == S_IDLE;
    assign take_q = cmd_ok && !is_imm && !qp_valid_r;
    // The queued put is fenced on its tag group and yields to immediate work.
    assign launch_q = state_r == S_IDLE && !take_imm && qp_valid_r && TAG_IDLE[qp_r.tag];

    ////////////////////////////////////////////////////////////////////////////
    // Reservation decode.
    logic hit_snoop, lose_ctx, lose_get, res_ok, res_set, res_drop;
    assign hit_snoop = res_valid_r && res_coh_r && SNOOP_VALID && same_granule(SNOOP_EA, res_ea_r);
    assign lose_ctx = res_valid_r && CTX_SWITCH;
    assign lose_get = take_imm && CMD.op == OP_GET_RESERVE && res_valid_r
                      && !same_granule(CMD.ea, res_ea_r);
    assign res_ok = res_valid_r && !hit_snoop && !CTX_SWITCH && same_granule(CMD.ea, res_ea_r);
    assign res_set = state_r == S_DONE && op_r == OP_GET_RESERVE && !CTX_SWITCH;
    // Every conditional put uses up the reservation, so a context switch put clears it.
    assign res_drop = hit_snoop || lose_ctx || lose_get || (take_imm && CMD.op == OP_PUT_COND);

    ////////////////////////////////////////////////////////////////////////////
    // Beat transfer decode.
    logic xfer, ms_state, fill_state, beat_done, last_beat, set_req, buf_we;
    logic [BEAT_W-1:0] buf_wdata;
    assign ms_state = state_r == S_MS_RD || state_r == S_MS_WR;
    assign fill_state = state_r == S_MS_RD || state_r == S_LS_RD;
    assign xfer = ms_state || state_r == S_LS_WR || state_r == S_LS_RD;
    assign beat_done = (ms_req_r && MS_ACK) || (ls_req_r && LS_ACK);
    assign last_beat = beat_r == LAST_BEAT;
    assign set_req = xfer && !ms_req_r && !ls_req_r;
    assign buf_we = beat_done && fill_state;
    assign buf_wdata = state_r == S_MS_RD ? MS_RDATA : LS_RDATA;
    assign beat_nxt = beat_done ? (last_beat ? '0 : beat_r + 1'h1) : beat_r;

    // Holds the line between its read side and its write side.
    line_buffer #(
        .WIDTH(BEAT_W),
        .DEPTH(BEATS),
        .AW(BEAT_LG2)
    ) u_line_buffer (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .wr_en(buf_we),
        .wr_addr(beat_r),
        .wr_data(buf_wdata),
        .rd_addr(beat_r),
        .rd_data(buf_rdata)
    );

    // Next state of the transfer engine.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: begin
                if (take_imm) begin
                    case (CMD.op)
                        OP_GET_RESERVE: state_nxt = S_MS_RD;
                        OP_PUT_COND: state_nxt = res_ok ? S_LS_RD : S_DONE;
                        default: state_nxt = S_LS_RD;
                    endcase
                end else if (launch_q) begin
                    state_nxt = S_LS_RD;
                end
            end
            S_MS_RD: if (beat_done && last_beat) state_nxt = S_LS_WR;
            S_LS_WR: if (beat_done && last_beat) state_nxt = S_DONE;
            S_LS_RD: if (beat_done && last_beat) state_nxt = S_MS_WR;
            S_MS_WR: if (beat_done && last_beat) state_nxt = S_DONE;
            default: state_nxt = S_IDLE;
        endcase
    end

    // Engine registers and the captured command.
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            state_r <= STATE_RESET;
            op_r <= OP_RESET;
            ls_off_r <= '0;
            ea_r <= '0;
            coh_r <= 1'h0;
            tag_r <= '0;
            beat_r <= '0;
        end else begin
            state_r <= state_nxt;
            beat_r <= beat_nxt;
            if (take_imm) begin
                op_r <= CMD.op;
                ls_off_r <= CMD.ls_off;
                ea_r <= CMD.ea;
                coh_r <= CMD.coh;
            end else if (launch_q) begin
                op_r <= OP_PUT_QUEUED;
                ls_off_r <= qp_r.ls_off;
                ea_r <= qp_r.ea;
                tag_r <= qp_r.tag;
            end
        end
    end

    // Per-beat requests; data for a write beat is read from the buffer a cycle ahead.
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            ms_req_r <= 1'h0;
            ls_req_r <= 1'h0;
            ms_we_r <= 1'h0;
            ls_we_r <= 1'h0;
            ms_addr_r <= '0;
            ls_addr_r <= '0;
        end else if (set_req) begin
            ms_req_r <= ms_state;
            ls_req_r <= !ms_state;
            ms_we_r <= state_r == S_MS_WR;
            ls_we_r <= state_r == S_LS_WR;
            ms_addr_r <= {ea_r[EA_W-1:LINE_LG2], beat_r, BYTE_LG2'(0)};
            ls_addr_r <= {ls_off_r[LS_AW-1:LINE_LG2], beat_r, BYTE_LG2'(0)};
        end else if (state_r == S_IDLE) begin
            // Clears the write marks so a failed conditional put never reports a store.
            ms_we_r <= 1'h0;
            ls_we_r <= 1'h0;
        end else begin
            ms_req_r <= ms_req_r && !MS_ACK;
            ls_req_r <= ls_req_r && !LS_ACK;
        end
    end

    // Command answers, busy tracking, halt and the queued put slot.
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            cmd_ack_r <= 1'h0;
            cmd_rej_r <= 1'h0;
            imm_busy_r <= 1'h0;
            halt_r <= 1'h0;
            host_int_r <= 1'h0;
            class1_r <= 1'h0;
            qp_valid_r <= 1'h0;
            qp_r <= '0;
            qdone_r <= 1'h0;
            qdone_tag_r <= '0;
        end else begin
            cmd_ack_r <= take_imm || take_q;
            cmd_rej_r <= rej_proxy || rej_attr || rej_overlap;
            class1_r <= rej_attr;
            host_int_r <= rej_overlap;
            halt_r <= halt_r || rej_overlap;
            imm_busy_r <= take_imm || (imm_busy_r && !(state_r == S_DONE && op_r != OP_PUT_QUEUED));
            qp_valid_r <= take_q || (qp_valid_r && !launch_q);
            if (take_q) begin
                qp_r <= CMD;
            end
            qdone_r <= state_r == S_DONE && op_r == OP_PUT_QUEUED;
            if (state_r == S_DONE) begin
                qdone_tag_r <= tag_r;
            end
        end
    end

    // Status: set on completion, taken by a read; a read with nothing pending waits until a completion sets it.
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            stat_r <= STAT_RESET;
            stat_data_r <= STAT_RESET;
            stat_pend_r <= 1'h0;
            stat_valid_r <= 1'h0;
        end else begin
            stat_valid_r <= STAT_RD && stat_pend_r && !stat_valid_r;
            if (STAT_RD && stat_pend_r && !stat_valid_r) begin
                stat_data_r <= stat_r;
            end
            if (state_r == S_DONE && op_r != OP_PUT_QUEUED) begin
                stat_r.get_done <= op_r == OP_GET_RESERVE;
                stat_r.put_uncond_done <= op_r == OP_PUT_UNCOND;
                stat_r.put_cond_ok <= op_r == OP_PUT_COND && ms_we_r;
                stat_r.put_cond_fail <= op_r == OP_PUT_COND && !ms_we_r;
                stat_pend_r <= 1'h1;
            end else if (STAT_RD && stat_pend_r && !stat_valid_r) begin
                stat_pend_r <= 1'h0;
            end
        end
    end

    // Reservation; the lost event only hints that the granule may have changed.
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            res_valid_r <= 1'h0;
            res_coh_r <= 1'h0;
            res_ea_r <= '0;
            res_lost_r <= 1'h0;
        end else begin
            res_lost_r <= hit_snoop || lose_ctx || lose_get;
            if (res_set) begin
                res_valid_r <= 1'h1;
                res_coh_r <= coh_r;
                res_ea_r <= ea_r;
            end else if (res_drop) begin
                res_valid_r <= 1'h0;
            end
        end
    end

    // Outputs, each from a flip-flop.
    assign CMD_ACK = cmd_ack_r;
    assign CMD_REJECT = cmd_rej_r;
    assign QPUT_DONE = qdone_r;
    assign QPUT_DONE_TAG = qdone_tag_r;
    assign STAT_VALID = stat_valid_r;
    assign STAT_DATA = stat_data_r;
    assign LS_REQ = ls_req_r;
    assign LS_WE = ls_we_r;
    assign LS_ADDR = ls_addr_r;
    assign LS_WDATA = buf_rdata;
    assign MS_REQ = ms_req_r;
    assign MS_WE = ms_we_r;
    assign MS_ADDR = ms_addr_r;
    assign MS_WDATA = buf_rdata;
    assign RES_LOST_EVT = res_lost_r;
    assign RES_HELD = res_valid_r;
    assign QUEUE_HALT = halt_r;
    assign HOST_INT = host_int_r;
    assign CLASS1_INT = class1_r;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);

    property p_proxy_refused;
        rej_proxy |=> CMD_REJECT && !CMD_ACK && !CLASS1_INT && !HOST_INT;
    endproperty
    a_proxy_refused: assert property (p_proxy_refused) else $error("proxy command not refused");

    property p_slot_needed;
        CMD_ACK |-> $past(QSLOT_FREE) && !$past(CMD.proxy);
    endproperty
    a_slot_needed: assert property (p_slot_needed) else $error("command taken without a queue slot");

    property p_bad_attr;
        rej_attr |=> CLASS1_INT && CMD_REJECT ##1 !CLASS1_INT;
    endproperty
    a_bad_attr: assert property (p_bad_attr) else $error("bad storage attribute not flagged");

    property p_overlap_halts;
        rej_overlap |=> HOST_INT && QUEUE_HALT ##1 QUEUE_HALT && !CMD_ACK;
    endproperty
    a_overlap_halts: assert property (p_overlap_halts) else $error("overlapping immediate did not halt");

    property p_cond_fail;
        take_imm && CMD.op == OP_PUT_COND && !res_ok |=> state_r == S_DONE ##1 !MS_REQ && !RES_HELD;
    endproperty
    a_cond_fail: assert property (p_cond_fail) else $error("failed conditional put went ahead");

    property p_uncond_stores;
        take_imm && CMD.op == OP_PUT_UNCOND |=> state_r == S_LS_RD ##2 LS_REQ && !LS_WE;
    endproperty
    a_uncond_stores: assert property (p_uncond_stores) else $error("unconditional put did not start");

    property p_get_reserves;
        state_r == S_DONE && op_r == OP_GET_RESERVE && !CTX_SWITCH |=> RES_HELD && stat_pend_r && stat_r.get_done;
    endproperty
    a_get_reserves: assert property (p_get_reserves) else $error("get-and-reserve left no reservation");

    property p_get_moves;
        take_imm && CMD.op == OP_GET_RESERVE |=> state_r == S_MS_RD ##2 MS_REQ && !MS_WE;
    endproperty
    a_get_moves: assert property (p_get_moves) else $error("get-and-reserve did not read main storage");

    property p_far_get;
        lose_get |=> RES_LOST_EVT && !RES_HELD;
    endproperty
    a_far_get: assert property (p_far_get) else $error("reservation kept on a foreign granule");

    property p_snoop_loss;
        hit_snoop && !res_set |=> RES_LOST_EVT && !RES_HELD;
    endproperty
    a_snoop_loss: assert property (p_snoop_loss) else $error("coherent store did not drop reservation");

    property p_ctx_loss;
        RES_HELD && CTX_SWITCH |=> RES_LOST_EVT && !RES_HELD;
    endproperty
    a_ctx_loss: assert property (p_ctx_loss) else $error("context switch kept reservation");

    property p_idle_read_stalls;
        STAT_RD && !stat_pend_r && !imm_busy_r |=> !STAT_VALID;
    endproperty
    a_idle_read_stalls: assert property (p_idle_read_stalls) else $error("status answered with none pending");

    property p_fence;
        state_r == S_IDLE && state_nxt == S_LS_RD && !take_imm |-> TAG_IDLE[qp_r.tag] && qp_valid_r;
    endproperty
    a_fence: assert property (p_fence) else $error("queued put passed its tag group");

    c_cond_ok: cover property (STAT_VALID && STAT_DATA.put_cond_ok);
    c_get_done: cover property (state_r == S_DONE && op_r == OP_GET_RESERVE);
    c_lost: cover property (RES_LOST_EVT);
    c_queued: cover property (QPUT_DONE);

endmodule : lockline_unit

// File: tb/mem_model.sv
/*
 * Responder for one memory port of the lock-line unit: it answers a held
 * request after WAIT+1 cycles with a one-cycle ack and read data.
 * Assumes the requester holds its request until ack and then drops it.
 */
`timescale 1ns/10ps
module mem_model #(
    parameter int WAIT = 1
) (
    input wire logic clk,
    input wire logic req,
    output logic ack,
    output logic [127:0] rdata
);
    logic [2:0] cnt_r;

    // Counts the wait. Read data holds the pattern except in the cycle after an ack, when it is inverted.
    always_ff @(posedge clk) begin
        ack <= req && !ack && cnt_r == 3'(WAIT);
        cnt_r <= (req && !ack) ? cnt_r + 3'h1 : 3'h0;
        rdata <= ack ? ~rdata : {4{32'hA5C3_0F1E}};
    end
endmodule : mem_model

// File: tb/lockline_unit_tb.sv
/*
 * Self-checking bench of the lock-line unit, one task per scenario.
 * Assumes the package and two memory responders on the local and main ports.
 */
`timescale 1ns/10ps
module lockline_unit_tb import lockline_pkg::*; ;
    localparam logic [63:0] EA1 = 64'h0000_0000_0001_2345;
    localparam logic [63:0] EA2 = 64'h0000_0000_0001_23C5;
    logic clk = 1'b0, rstn = 1'b0, cv = 1'b0, qf = 1'b1, srd = 1'b0, snp = 1'b0, ctx = 1'b0;
    logic ack, rej, qd, sv, lsq, lswe, ls_ack, msq, mswe, msa, lost, held, halt, hi, c1i;
    logic [31:0] tid = 32'hFFFF_FFFF;
    logic [4:0] qtag;
    logic [3:0] r;
    logic [127:0] lsr, msr, lswd, mswd;
    cmd_t cmd = '0;
    stat_t sd;
    int num_errors = 0, n_checks = 0, lsw_n = 0, lsr_n = 0, msw_n = 0, lost_n = 0, qd_n = 0, bad_n = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Design, memory responders and counters of acked beats and pulses.
    lockline_unit dut (.CORE_CLK(clk), .RSTN(rstn), .CMD_VALID(cv), .CMD(cmd), .QSLOT_FREE(qf),
        .CMD_ACK(ack), .CMD_REJECT(rej), .TAG_IDLE(tid), .QPUT_DONE(qd), .QPUT_DONE_TAG(qtag),
        .STAT_RD(srd), .STAT_VALID(sv), .STAT_DATA(sd), .LS_REQ(lsq), .LS_WE(lswe), .LS_ADDR(),
        .LS_WDATA(lswd), .LS_RDATA(lsr), .LS_ACK(ls_ack), .MS_REQ(msq), .MS_WE(mswe), .MS_ADDR(),
        .MS_WDATA(mswd), .MS_RDATA(msr), .MS_ACK(msa), .SNOOP_VALID(snp), .SNOOP_EA(EA1),
        .CTX_SWITCH(ctx), .RES_LOST_EVT(lost), .RES_HELD(held), .QUEUE_HALT(halt),
        .HOST_INT(hi), .CLASS1_INT(c1i));
    mem_model #(.WAIT(1)) u_ls (.clk(clk), .req(lsq), .ack(ls_ack), .rdata(lsr));
    mem_model #(.WAIT(5)) u_ms (.clk(clk), .req(msq), .ack(msa), .rdata(msr));
    always @(posedge clk) begin
        lsw_n += ls_ack & lswe;
        lsr_n += ls_ack & !lswe;
        // Written beats must carry the line that the responders handed over.
        bad_n += ls_ack & lswe & (lswd !== {4{32'hA5C3_0F1E}});
        bad_n += msa & mswe & (mswd !== {4{32'hA5C3_0F1E}});
        msw_n += msa & mswe;
        lost_n += lost;
        qd_n += qd;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared compare, command, status read and pulse tasks.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    // Holds the command until ack or reject; r is {ack, reject, class1, host}.
    task automatic issue(input op_t op, input logic [63:0] ea, input logic [3:0] fl);
        @(negedge clk);
        cmd = '{op, 5'h03, 18'h00140, ea, fl[3], fl[2], fl[1], fl[0]};
        cv = 1'b1;
        r = 4'h0;
        for (int i = 0; i < 300 && r == 4'h0; i++) begin
            @(negedge clk);
            r = {ack, rej, c1i, hi};
        end
        cv = 1'b0;
    endtask : issue
    // The issuer reads status after every taken immediate command except the get in t_halt.
    task automatic stat(input logic [3:0] exp);
        srd = 1'b1;
        for (int i = 0; i < 300 && sv !== 1'b1; i++) @(negedge clk);
        chk(8'({sv, sd}), 8'({1'b1, exp}));
        srd = 1'b0;
    endtask : stat
    task automatic pulse(ref logic x);
        @(negedge clk);
        x = 1'b1;
        @(negedge clk);
        x = 1'b0;
        repeat (3) @(negedge clk);
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_fail;
        int m = msw_n;
        issue(OP_PUT_COND, EA1, 4'h2);
        chk(8'(r), 8'h08);
        stat(4'h1);
        chk(8'(msw_n - m), 8'h00);
    endtask : t_fail
    task automatic t_get(input logic [63:0] ea);
        int l = lsw_n;
        issue(OP_GET_RESERVE, ea, 4'h2);
        chk(8'(r), 8'h08);
        stat(4'h8);
        chk(8'({held, 7'(lsw_n - l)}), 8'h88);
    endtask : t_get
    task automatic t_ok;
        int m = msw_n, l = lsr_n;
        t_get(EA1);
        issue(OP_PUT_COND, EA1, 4'h2);
        stat(4'h2);
        chk(8'(msw_n - m), 8'h08);
        chk(8'({held, 7'(lsr_n - l)}), 8'h08);
        m = msw_n;
        issue(OP_PUT_UNCOND, EA1, 4'h2);
        stat(4'h4);
        chk(8'(msw_n - m), 8'h08);
        chk(8'(bad_n), 8'h00);
    endtask : t_ok
    task automatic t_refuse;
        issue(OP_PUT_UNCOND, EA1, 4'h3);
        chk(8'(r), 8'h04);
        issue(OP_GET_RESERVE, EA1, 4'hA);
        chk(8'(r), 8'h06);
        issue(OP_PUT_QUEUED, EA1, 4'h6);
        chk(8'(r), 8'h06);
    endtask : t_refuse
    task automatic t_lost;
        int n = lost_n;
        t_get(EA1);
        pulse(snp);
        chk(8'({held, 7'(lost_n - n)}), 8'h01);
        t_get(EA2);
        t_get(EA1);
        chk(8'(lost_n - n), 8'h02);
        pulse(ctx);
        chk(8'({held, 7'(lost_n - n)}), 8'h03);
    endtask : t_lost
    task automatic t_queue;
        int n = qd_n;
        tid = 32'h0;
        issue(OP_PUT_QUEUED, EA1, 4'h2);
        chk(8'(r), 8'h08);
        t_fail;
        chk(8'(qd_n - n), 8'h00);
        tid = 32'hFFFF_FFFF;
        for (int i = 0; i < 300 && qd !== 1'b1; i++) @(negedge clk);
        chk(8'({qd, qtag}), 8'h23);
        chk(8'(bad_n), 8'h00);
    endtask : t_queue
    task automatic t_slot;
        qf = 1'b0;
        fork
            issue(OP_PUT_COND, EA1, 4'h2);
            begin
                repeat (20) @(negedge clk);
                chk(8'(r), 8'h00);
                qf = 1'b1;
            end
        join
        chk(8'(r), 8'h08);
        stat(4'h1);
    endtask : t_slot
    task automatic t_halt;
        issue(OP_GET_RESERVE, EA2, 4'h2);
        issue(OP_PUT_COND, EA2, 4'h2);
        @(negedge clk);
        chk(8'({halt, 3'h0, r}), 8'h85);
    endtask : t_halt
    task automatic close_out;
        if (num_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, reset, sequence and watchdog.
    initial forever #2 clk = ~clk;
    initial begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        t_fail;
        t_ok;
        t_refuse;
        t_lost;
        t_queue;
        t_slot;
        t_halt;
        close_out();
    end
    initial begin
        #100000;
        num_errors++;
        close_out();
    end
endmodule : lockline_unit_tb
